// ===== rtl/pipelined_burst_sram_port.sv
/*
 * Pipelined burst SRAM access port with per-lane error correction, byte-lane
 * writes, three chip selects, linear or interleaved bursts and a write buffer.
 * Assumes the host drives every synchronous input on i_clk; only the output
 * enable and the burst order strap arrive from outside and are synchronised.
 */
// Behaviour
// - Address, controls, lane selects and write data are taken on rising edges only.
// - Read data leaves through output flip-flops, never flow-through.
// - With the clock qualifier high, pipeline, read data and flag hold; output enable and buffered writes still act.
// - Data drivers turn off on their own during each write data phase.
// - Writes complete internally on the clock without host pulse shaping.
// - Write request plus per-lane selects decide writes; only selected lanes change.
// - Selected only when all three chip selects are active; otherwise a deselect.
// - Output enable high turns the data drivers off regardless of operations.
// - Reads and writes in any mix run back to back without wait states.
// - Bursts follow linear or interleaved order, picked by a configuration input.
// - Each stored lane carries a code; single-bit errors are fixed on read.
// - Advance high steps the burst counter; low loads; load after a deselect.
// - Lane selects are active low and each covers one byte plus its parity.
// - Chip select two is active high, one and three active low, all clocked.
`timescale 1ns/10ps

// ==========================================================
// Write buffer
module sram_wbuf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [PTR_W:0]   count_r;
   logic             push;
   logic             pop;
   assign o_in_ready  = (count_r != (PTR_W+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = store[rd_ptr_r];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   always_ff @(posedge i_clk) begin
      if (push) begin
         store[wr_ptr_r] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end
endmodule

// ==========================================================
// Access port
module pipelined_burst_sram_port
   import sram_port_pkg::*;
#(
   parameter int LANES  = LANES_WIDE,
   parameter int ADDR_W = ADDR_W_WIDE
) (
   // Clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_resetn,
   // Host command
   input  wire logic [ADDR_W-1:0]             i_addr,
   input  wire logic                          i_write_n,
   input  wire logic [LANES-1:0]              i_byte_lane_select_n,
   input  wire logic                          i_chip_select_1_n,
   input  wire logic                          i_chip_select_2,
   input  wire logic                          i_chip_select_3_n,
   input  wire logic                          i_burst_advance_or_load,
   input  wire logic                          i_clock_qualify_n,
   // Asynchronous controls
   input  wire logic                          i_output_enable_n,
   input  wire logic                          i_burst_linear,
   // Data and parity pins
   input  wire logic [LANES*LANE_DATA_W-1:0]  i_data,
   output logic      [LANES*LANE_DATA_W-1:0]  o_data,
   output logic                               o_data_oe_n,
   // Status
   output logic                               o_corrected
);
   localparam int DATA_W = LANES * LANE_DATA_W;
   localparam int DEPTH  = 1 << ADDR_W;
   localparam int ENTRY_W = ADDR_W + LANES + LANES * CODE_W;
   // ==========================================================
   // Code functions
   function automatic logic is_check_pos(input int p);
      return (p & (p - 1)) == 0;
   endfunction
   function automatic logic [CODE_W-1:0] ecc_encode(input logic [LANE_DATA_W-1:0] d);
      logic [CODE_W-1:0] c;
      int                k;
      c = '0;
      k = 0;
      for (int p = 1; p <= CODE_W; p++) begin
         if (!is_check_pos(p)) begin
            c[p-1] = d[k];
            k++;
         end
      end
      for (int b = 0; b < CHECK_W; b++) begin
         for (int p = 1; p <= CODE_W; p++) begin
            if (((p >> b) & 1) == 1 && !is_check_pos(p)) begin
               c[(1 << b) - 1] = c[(1 << b) - 1] ^ c[p-1];
            end
         end
      end
      return c;
   endfunction
   function automatic logic [CHECK_W-1:0] ecc_syndrome(input logic [CODE_W-1:0] c);
      logic [CHECK_W-1:0] s;
      s = '0;
      for (int b = 0; b < CHECK_W; b++) begin
         for (int p = 1; p <= CODE_W; p++) begin
            if (((p >> b) & 1) == 1) begin
               s[b] = s[b] ^ c[p-1];
            end
         end
      end
      return s;
   endfunction
   function automatic logic [LANE_DATA_W-1:0] ecc_decode(input logic [CODE_W-1:0] c);
      logic [CODE_W-1:0]      f;
      logic [CHECK_W-1:0]     s;
      logic [LANE_DATA_W-1:0] d;
      int                     k;
      f = c;
      s = ecc_syndrome(c);
      d = '0;
      k = 0;
      for (int p = 1; p <= CODE_W; p++) begin
         if (s == CHECK_W'(p)) begin
            f[p-1] = ~c[p-1];
         end
      end
      for (int p = 1; p <= CODE_W; p++) begin
         if (!is_check_pos(p)) begin
            d[k] = f[p-1];
            k++;
         end
      end
      return d;
   endfunction
   function automatic logic [BURST_W-1:0] burst_step(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic               linear);
      return linear ? base + cnt : base ^ cnt;
   endfunction
   // ==========================================================
   // Synchronisers for pins without timing to i_clk
   logic oe_meta_r;
   logic oe_sync_r;
   logic lin_meta_r;
   logic lin_sync_r;
   always_ff @(posedge i_clk) begin
      oe_meta_r  <= ~i_output_enable_n;
      oe_sync_r  <= oe_meta_r;
      lin_meta_r <= i_burst_linear;
      lin_sync_r <= lin_meta_r;
   end
   // ==========================================================
   // Pipeline control
   op_t                s1_op_r;
   op_t                s2_op_r;
   logic [ADDR_W-1:0]  s1_addr_r;
   logic [ADDR_W-1:0]  s2_addr_r;
   logic [LANES-1:0]   s1_bw_n_r;
   logic [LANES-1:0]   s2_bw_n_r;
   logic [ADDR_W-1:0]  base_r;
   logic [BURST_W-1:0] cnt_r;
   logic               selected;
   logic               run;
   logic               arr_rd;
   logic               wb_in_valid;
   logic               wb_in_ready;
   logic               wb_out_valid;
   logic [ENTRY_W-1:0] wb_in_data;
   logic [ENTRY_W-1:0] wb_out_data;
   logic [BURST_W-1:0] cnt_nxt;
   assign selected = ~i_chip_select_1_n & i_chip_select_2 & ~i_chip_select_3_n;
   // A full buffer holds the pipeline like a deasserted qualifier
   assign wb_in_valid = (s2_op_r == OP_WRITE) & ~i_clock_qualify_n;
   assign run = ~i_clock_qualify_n & (wb_in_ready | (s2_op_r != OP_WRITE));
   // Separate array read and write ports let the buffer drain on every edge, so it never stalls the host
   assign arr_rd  = run & (s1_op_r == OP_READ);
   assign cnt_nxt = cnt_r + 1'b1;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s1_op_r   <= OP_IDLE;
         s1_addr_r <= '0;
         s1_bw_n_r <= '1;
         base_r    <= '0;
         cnt_r     <= RST_COUNT;
      end else if (run) begin
         s1_bw_n_r <= i_byte_lane_select_n;
         if (!i_burst_advance_or_load) begin
            base_r    <= i_addr;
            cnt_r     <= RST_COUNT;
            s1_addr_r <= i_addr;
            if (selected) begin
               s1_op_r <= i_write_n ? OP_READ : OP_WRITE;
            end else begin
               s1_op_r <= OP_IDLE;
            end
         end else if (s1_op_r != OP_IDLE) begin
            // Advance keeps the burst's direction; after a deselect it does nothing
            cnt_r     <= cnt_nxt;
            s1_addr_r <= {base_r[ADDR_W-1:BURST_W],
                          burst_step(base_r[BURST_W-1:0], cnt_nxt, lin_sync_r)};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s2_op_r   <= OP_IDLE;
         s2_addr_r <= '0;
         s2_bw_n_r <= '1;
      end else if (run) begin
         s2_op_r   <= s1_op_r;
         s2_addr_r <= s1_addr_r;
         s2_bw_n_r <= s1_bw_n_r;
      end
   end
   // ==========================================================
   // Write data capture and buffer
   logic [LANES*CODE_W-1:0] wr_code;
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_enc
         assign wr_code[g*CODE_W +: CODE_W] = ecc_encode(i_data[g*LANE_DATA_W +: LANE_DATA_W]);
      end
   endgenerate
   // Write data is taken two qualified edges after its address
   assign wb_in_data = {s2_addr_r, s2_bw_n_r, wr_code};
   sram_wbuf #(
      .WIDTH (ENTRY_W),
      .DEPTH (WBUF_DEPTH)
   ) u_wbuf (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (wb_in_valid),
      .i_in_data   (wb_in_data),
      .o_in_ready  (wb_in_ready),
      .o_out_valid (wb_out_valid),
      .o_out_data  (wb_out_data),
      .i_out_ready (1'b1)
   );
   // ==========================================================
   // Storage, one array per lane
   logic [ADDR_W-1:0]       wr_addr;
   logic [LANES-1:0]        wr_bw_n;
   logic [LANES*CODE_W-1:0] rd_code_r;
   assign wr_addr = wb_out_data[ENTRY_W-1 -: ADDR_W];
   assign wr_bw_n = wb_out_data[LANES*CODE_W +: LANES];
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [CODE_W-1:0] mem [0:DEPTH-1];
         always_ff @(posedge i_clk) begin
            if (arr_rd) begin
               rd_code_r[g*CODE_W +: CODE_W] <= mem[s1_addr_r];
            end
            if (wb_out_valid && !wr_bw_n[g]) begin
               mem[wr_addr] <= wb_out_data[g*CODE_W +: CODE_W];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read output registers and driver control
   logic [DATA_W-1:0] rd_fixed;
   logic              rd_err;
   logic              drive_r;
   logic              drive_nxt;
   always_comb begin
      rd_fixed = '0;
      rd_err   = 1'b0;
      for (int l = 0; l < LANES; l++) begin
         rd_fixed[l*LANE_DATA_W +: LANE_DATA_W] = ecc_decode(rd_code_r[l*CODE_W +: CODE_W]);
         rd_err = rd_err | (ecc_syndrome(rd_code_r[l*CODE_W +: CODE_W]) != '0);
      end
   end
   assign drive_nxt = run ? (s2_op_r == OP_READ) : drive_r;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_data      <= '0;
         o_corrected <= RST_FLAG;
      end else if (run && s2_op_r == OP_READ) begin
         o_data      <= rd_fixed;
         o_corrected <= rd_err;
      end
   end
   // Enable is refreshed every edge so the output enable acts even while stalled
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         drive_r     <= RST_DRIVE;
         o_data_oe_n <= RST_OE_N;
      end else begin
         drive_r     <= drive_nxt;
         o_data_oe_n <= ~(drive_nxt & oe_sync_r);
      end
   end

endmodule

// ===== rtl/sram_port_pkg.sv
/*
 * Shared constants for the pipelined burst SRAM port: lane layout, error
 * correction code geometry, burst counter width, buffer depth and reset
 * values.
 * Assumes a single rising-edge clock domain and no software-visible registers.
 */
package sram_port_pkg;

   // ==========================================================
   // Lane and word layout
   localparam int LANE_DATA_W  = 9;   // Eight data bits plus one parity bit
   localparam int LANES_WIDE   = 4;
   localparam int LANES_NARROW = 2;
   localparam int ADDR_W_WIDE  = 20;
   localparam int ADDR_W_NARROW = 21;

   // ==========================================================
   // Single-error-correcting code, per lane
   localparam int CHECK_W = 4;
   localparam int CODE_W  = LANE_DATA_W + CHECK_W;

   // ==========================================================
   // Burst and buffering
   localparam int BURST_W    = 2;
   localparam int WBUF_DEPTH = 8;

   // ==========================================================
   // Reset values
   localparam logic RST_DRIVE   = 1'b0;
   localparam logic RST_OE_N    = 1'b1;
   localparam logic RST_FLAG    = 1'b0;
   localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;

   // Operation carried by each pipeline stage
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } op_t;

endpackage

// ===== dv/sram_port_properties.sv
/* Pin-level assertions for the SRAM access port.
   Assumes it is bound to the top module with its parameters. */
`timescale 1ns/10ps
module sram_port_properties
   import sram_port_pkg::*;
#(
   parameter int LANES  = 4,
   parameter int ADDR_W = 6
) (
   input wire logic                         i_clk,
   input wire logic                         i_resetn,
   input wire logic                         i_write_n,
   input wire logic                         i_chip_select_1_n,
   input wire logic                         i_chip_select_2,
   input wire logic                         i_chip_select_3_n,
   input wire logic                         i_burst_advance_or_load,
   input wire logic                         i_clock_qualify_n,
   input wire logic                         i_output_enable_n,
   input wire logic [LANES*LANE_DATA_W-1:0] o_data,
   input wire logic                         o_data_oe_n,
   input wire logic                         o_corrected
);
   logic [2:0] oe_low_r;
   logic       oe_ok;
   logic       sel;
   // Output enable passes a synchroniser, so only long low runs count
   always_ff @(posedge i_clk) begin
      if (!i_resetn || i_output_enable_n) oe_low_r <= 3'h0;
      else if (oe_low_r != 3'h7) oe_low_r <= oe_low_r + 3'h1;
   end
   assign oe_ok = oe_low_r >= 3'h5;
   assign sel = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_load;
      !i_clock_qualify_n && !i_burst_advance_or_load;
   endsequence
   sequence s_rd;
      s_load ##0 (i_write_n && sel);
   endsequence
   sequence s_wr;
      s_load ##0 (!i_write_n && sel);
   endsequence
   sequence s_two;
      !i_clock_qualify_n [*2];
   endsequence
   // ==========================================================
   // Properties
   AST_READ_LAT: assert property (s_rd ##1 s_two |=> (!o_data_oe_n || !oe_ok))
      else $error("read data not driven two edges after load");
   AST_WR_OFF: assert property (s_wr ##1 s_two |=> o_data_oe_n)
      else $error("drivers on in write data phase");
   AST_STALL: assert property (i_clock_qualify_n |=> $stable(o_data) && $stable(o_corrected))
      else $error("outputs moved while stalled");
   AST_DESEL: assert property (s_load ##0 !sel ##1 s_two |=> o_data_oe_n)
      else $error("deselect drove the bus");
   AST_OE_OFF: assert property (i_output_enable_n [*4] |-> o_data_oe_n)
      else $error("drivers on with output enable high");
   AST_DATA_HOLD: assert property ($changed(o_data) |-> (!o_data_oe_n || !oe_ok))
      else $error("read data changed outside a read beat");
   AST_B2B: assert property (s_rd ##1 (!i_clock_qualify_n && i_burst_advance_or_load) ##1 s_two
      |-> (!o_data_oe_n || !oe_ok) [*2])
      else $error("burst read beats not back to back");
   AST_WR_RD: assert property (s_wr ##1 s_rd ##1 s_two |=> (!o_data_oe_n || !oe_ok))
      else $error("read after write delayed");
endmodule

// ===== dv/sram_host_model.sv
/* Host memory controller model: issues commands and presents write data.
   Assumes tasks are called just after a rising edge. */
`timescale 1ns/10ps
module sram_host_model
   import sram_port_pkg::*;
#(
   parameter int LANES  = 4,
   parameter int ADDR_W = 6
) (
   input  wire logic                    i_clk,
   // Command
   output logic [ADDR_W-1:0]            o_addr,
   output logic                         o_write_n,
   output logic [LANES-1:0]             o_byte_lane_select_n,
   output logic                         o_chip_select_1_n,
   output logic                         o_chip_select_2,
   output logic                         o_chip_select_3_n,
   output logic                         o_burst_advance_or_load,
   output logic                         o_clock_qualify_n,
   // Write data
   output logic [LANES*LANE_DATA_W-1:0] o_data
);
   localparam int DW = LANES*LANE_DATA_W;
   logic          cur_v = 1'b0;
   logic          st_v = 1'b0;
   logic          tv;
   logic [DW-1:0] cur_d;
   logic [DW-1:0] st_d;
   logic [DW-1:0] td;
   initial begin
      o_addr = '0;
      o_write_n = 1'b1;
      o_byte_lane_select_n = '1;
      o_burst_advance_or_load = 1'b0;
      {o_chip_select_1_n, o_chip_select_2, o_chip_select_3_n} = 3'h4;
      o_clock_qualify_n = 1'b0;
      o_data = '0;
   end
   // Data lands two qualified edges after its command; an idle bus toggles so stale data never matches
   always @(posedge i_clk) begin
      if (!o_clock_qualify_n) begin
         tv = cur_v;
         td = cur_d;
         #1;
         o_data = st_v ? st_d : ~o_data;
         st_v = tv;
         st_d = td;
      end
   end
   task automatic cmd(input logic wr, input logic adv, input logic [2:0] off, input logic [ADDR_W-1:0] a,
                      input logic [DW-1:0] d, input logic [LANES-1:0] bl);
      o_write_n = !wr;
      o_burst_advance_or_load = adv;
      o_chip_select_1_n = off[0];
      o_chip_select_2 = !off[1];
      o_chip_select_3_n = off[2];
      o_addr = a;
      o_byte_lane_select_n = bl;
      cur_v = wr && (adv || off == 3'h0);
      cur_d = d;
      @(posedge i_clk);
      #1;
   endtask
   task automatic stall(input int n);
      o_clock_qualify_n = 1'b1;
      repeat (n) @(posedge i_clk);
      #1;
      o_clock_qualify_n = 1'b0;
   endtask
endmodule

// ===== dv/tb.sv
/* Self-checking bench for the SRAM access port with random and directed traffic.
   Assumes the host model drives commands; the bench drives reset, enable and order. */
`timescale 1ns/10ps
module tb
   import sram_port_pkg::*;
;
   localparam int LANES = 4;
   localparam int AW = 6;
   localparam int DW = LANES*LANE_DATA_W;
   logic i_clk = 1'b0, i_resetn, i_output_enable_n, i_burst_linear, i_write_n, i_chip_select_1_n;
   logic i_chip_select_2, i_chip_select_3_n, i_burst_advance_or_load, i_clock_qualify_n;
   logic o_data_oe_n, o_corrected, nv, p0v = 1'b0, p1v = 1'b0, t_v;
   logic [AW-1:0]    i_addr;
   logic [LANES-1:0] i_byte_lane_select_n;
   logic [DW-1:0]    i_data, o_data, nd, p0d, p1d, t_d;
   logic [DW-1:0]    mem [64];
   logic [31:0]      seed = 32'h89A191DB;
   int               mismatches = 0;
   int               cmp_count = 0;
   int               cyc = 0;
   always #25 i_clk = ~i_clk;
   pipelined_burst_sram_port #(.LANES(LANES), .ADDR_W(AW)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_write_n(i_write_n), .i_byte_lane_select_n(i_byte_lane_select_n),
      .i_chip_select_1_n(i_chip_select_1_n), .i_chip_select_2(i_chip_select_2),
      .i_chip_select_3_n(i_chip_select_3_n), .i_burst_advance_or_load(i_burst_advance_or_load),
      .i_clock_qualify_n(i_clock_qualify_n), .i_output_enable_n(i_output_enable_n),
      .i_burst_linear(i_burst_linear), .i_data(i_data), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
      .o_corrected(o_corrected));
   sram_host_model #(.LANES(LANES), .ADDR_W(AW)) u_host (.i_clk(i_clk), .o_addr(i_addr),
      .o_write_n(i_write_n), .o_byte_lane_select_n(i_byte_lane_select_n),
      .o_chip_select_1_n(i_chip_select_1_n), .o_chip_select_2(i_chip_select_2),
      .o_chip_select_3_n(i_chip_select_3_n), .o_burst_advance_or_load(i_burst_advance_or_load),
      .o_clock_qualify_n(i_clock_qualify_n), .o_data(i_data));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, d, input logic [LANES-1:0] bl);
      for (int i = 0; i < LANES; i++) if (!bl[i]) old[i*LANE_DATA_W +: LANE_DATA_W] = d[i*LANE_DATA_W +: LANE_DATA_W];
      return old;
   endfunction
   function automatic logic [AW-1:0] beat(input logic [AW-1:0] b, input int n);
      return {b[AW-1:2], i_burst_linear ? b[1:0] + 2'(n) : b[1:0] ^ 2'(n)};
   endfunction
   task automatic chk(input string what, input logic [DW-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic op(input logic wr, adv, input logic [2:0] off, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, input logic [LANES-1:0] bl);
      if (off == 3'h0 && wr) mem[a] = merge(mem[a], d, bl);
      nv = !wr && off == 3'h0 && !i_output_enable_n;
      nd = mem[a];
      u_host.cmd(wr, adv, off, a, d, bl);
   endtask
   // Deselects rotate through each chip select in turn
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) op(1'b0, 1'b0, 3'(1 << (i % 3)), AW'(i), '0, '1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // Read pipeline follows qualified edges only, so stalls shift nothing
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         summarize();
      end
      if (i_resetn && !i_clock_qualify_n) begin
         t_v = nv;
         t_d = nd;
         nv = 1'b0;
         #2;
         if (p1v) begin
            chk("read data", o_data, p1d);
            chk("drive enable", o_data_oe_n, 1'b0);
            chk("corrected flag", o_corrected, 1'b0);
         end
         p1v = p0v;
         p1d = p0d;
         p0v = t_v;
         p0d = t_d;
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [AW-1:0] b;
      nv = 1'b0;
      i_resetn = 1'b0;
      i_output_enable_n = 1'b0;
      i_burst_linear = 1'b1;
      repeat (10) @(posedge i_clk);
      #1;
      i_resetn = 1'b1;
      chk("reset drive enable", o_data_oe_n, 1'b1);
      // Memory is not cleared by reset
      for (int a = 0; a < 64; a++) op(1'b1, 1'b0, 3'h0, AW'(a), DW'({rnd(), rnd()}), '0);
      idle(16);
      $display("test init done");
      // Reads stay clear of buffered writes
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         if (r[0]) op(1'b1, 1'b0, 3'h0, {2'h2, r[4:1]}, DW'({rnd(), r}), r[8:5]);
         else op(1'b0, 1'b0, 3'h0, {2'h0, r[4:1]}, '0, '1);
      end
      idle(16);
      for (int a = 32; a < 48; a++) op(1'b0, 1'b0, 3'h0, AW'(a), '0, '1);
      idle(4);
      $display("test mixed done");
      for (int m = 0; m < 2; m++) begin
         i_burst_linear = m[0];
         idle(4);
         b = AW'(6 + m * 3);
         for (int n = 0; n < 4; n++) op(1'b1, n != 0, 3'h0, beat(b, n), DW'({rnd(), rnd()}), '0);
         idle(16);
         for (int k = 0; k < 8; k++) op(1'b0, k > 4, 3'h0, beat(b, k % 4), '0, '1);
         idle(4);
      end
      $display("test burst done");
      op(1'b1, 1'b0, 3'h0, 6'h3, DW'(rnd()), '0);
      op(1'b0, 1'b0, 3'h0, 6'h5, '0, '1);
      u_host.stall(3);
      op(1'b0, 1'b0, 3'h0, 6'h4, '0, '1);
      u_host.stall(2);
      idle(16);
      $display("test stall done");
      i_output_enable_n = 1'b1;
      idle(4);
      op(1'b0, 1'b0, 3'h0, 6'h5, '0, '1);
      idle(3);
      chk("disabled drive enable", o_data_oe_n, 1'b1);
      i_output_enable_n = 1'b0;
      idle(4);
      $display("test enable done");
      summarize();
   end
endmodule
bind pipelined_burst_sram_port sram_port_properties #(.LANES(LANES), .ADDR_W(ADDR_W)) u_props (.*);
